// File: hw/rmf_pkg.sv
// rate match fifo package: widths, marks, filler code, cluster states
// assumes 10-bit aligned symbols, two lanes per word in double width
package rmf_pkg;

  // ****************************************
  // symbol and word layout
  // ****************************************
  localparam int RMF_SYM_W = 10;
  localparam int RMF_WORD_W = 20;
  localparam int RMF_LO_LSB = 0;
  localparam int RMF_HI_LSB = 10;
  localparam logic [9:0] RMF_FILL = 10'h1FE;
  localparam logic [9:0] RMF_ZERO = 10'h000;

  // ****************************************
  // fifo depth and fill marks
  // ****************************************
  localparam int RMF_DEPTH = 16;
  localparam int RMF_HI_MARK = 12;
  localparam int RMF_LO_MARK = 4;

  // ****************************************
  // single width cluster limits
  // ****************************************
  localparam logic [2:0] RMF_SW_MAX_INS = 3'h4;
  localparam logic [2:0] RMF_SW_MAX_CLUS = 3'h5;
  localparam logic [2:0] RMF_SW_MAX_DEL = 3'h4;
  localparam logic [2:0] RMF_CNT_SAT = 3'h7;
  localparam logic [2:0] RMF_CNT_ONE = 3'h1;
  localparam logic [2:0] RMF_CNT_ZERO = 3'h0;

  typedef enum logic {rmf_outside, rmf_inside} rmf_clus_t;

  // compare one symbol with a pattern
  function automatic logic rmf_sym_match(input logic [9:0] sym, input logic [9:0] pat);
    rmf_sym_match = (sym == pat);
  endfunction

  // saturating cluster counter step
  function automatic logic [2:0] rmf_inc(input logic [2:0] v);
    rmf_inc = (v == RMF_CNT_SAT) ? v : v + RMF_CNT_ONE;
  endfunction

endpackage

// File: hw/rmf_cls.sv
// rate match word classifier: control and skip flags per lane
// assumes match pattern holds control in high half, skip in low half
`timescale 1ns/1ps
module rmf_cls
(
  input wire logic [19:0] word,
  input wire logic [19:0] match_pattern,
  output logic [1:0] is_ctrl,
  output logic [1:0] is_skip
);

  // ****************************************
  // per lane compare
  // ****************************************
  always_comb
  begin
    is_ctrl[0] = rmf_pkg::rmf_sym_match(word[9:0], match_pattern[19:10]);
    is_ctrl[1] = rmf_pkg::rmf_sym_match(word[19:10], match_pattern[19:10]);
    is_skip[0] = rmf_pkg::rmf_sym_match(word[9:0], match_pattern[9:0]);
    is_skip[1] = rmf_pkg::rmf_sym_match(word[19:10], match_pattern[9:0]);
  end

endmodule

// File: hw/rmf_fifo.sv
// rate match storage: single clock fifo with level, full and empty
// assumes caller never pops when empty; writes when full are dropped
`timescale 1ns/1ps
module rmf_fifo #(
  parameter int WIDTH = 20,
  parameter int DEPTH = 16,
  localparam int AW = $clog2(DEPTH),
  localparam int CW = $clog2(DEPTH + 1)
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic rd_en,
  output logic [WIDTH-1:0] rd_data,
  output logic [CW-1:0] level,
  output logic full,
  output logic empty
);

  initial
  begin
    if (DEPTH < 4 || (1 << AW) != DEPTH)
      $error("rmf_fifo depth must be a power of two of at least 4");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [CW-1:0] lvl_q, lvl_d;
  logic do_wr, do_rd;

  // ****************************************
  // pointer and level update
  // ****************************************
  always_comb
  begin
    do_wr = wr_en && (lvl_q != CW'(DEPTH));
    do_rd = rd_en && (lvl_q != '0);
    wp_d = do_wr ? wp_q + AW'(1) : wp_q;
    rp_d = do_rd ? rp_q + AW'(1) : rp_q;
    lvl_d = lvl_q;
    if (do_wr && !do_rd)
      lvl_d = lvl_q + CW'(1);
    else if (do_rd && !do_wr)
      lvl_d = lvl_q - CW'(1);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wp_q <= '0;
      rp_q <= '0;
      lvl_q <= '0;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      lvl_q <= lvl_d;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (do_wr)
      mem[wp_q] <= wr_data;
  end

  assign rd_data = mem[rp_q];
  assign level = lvl_q;
  assign full = (lvl_q == CW'(DEPTH));
  assign empty = (lvl_q == '0);

endmodule

// File: hw/rmf_top.sv
// rate match fifo top: skip deletion on write, insertion and filler on read
// assumes aligned 8b/10b symbols in and one read request per output slot
`timescale 1ns/1ps

// Overview of operation
// - match pattern is configurable 20-bit value
// - match control then skip after alignment
// - insert or delete skips to hold level
// - single: insert at most four, cluster five
// - single: delete at most four, keep one
// - single: drop byte that hits full
// - single: filler code after emptying byte
// - double: insert skips only as pairs
// - double: delete skips only as pairs
// - double: split skips never deleted
// - double: odd deletion need takes pair
// - double: drop word that hits full
module rmf_top #(
  parameter int DEPTH = rmf_pkg::RMF_DEPTH,
  parameter int HI_MARK = rmf_pkg::RMF_HI_MARK,
  parameter int LO_MARK = rmf_pkg::RMF_LO_MARK,
  localparam int CW = $clog2(DEPTH + 1)
)
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic sync_ok,
  input wire logic dw_mode,
  input wire logic [19:0] match_pattern,
  input wire logic in_valid,
  input wire logic [19:0] in_data,
  input wire logic out_req,
  output logic out_valid,
  output logic [19:0] out_data,
  output logic out_filler,
  output logic rm_del,
  output logic rm_ins,
  output logic full_drop,
  output logic [CW-1:0] fifo_level
);

  initial
  begin
    if (HI_MARK >= DEPTH || LO_MARK < 1 || LO_MARK >= HI_MARK)
      $error("rmf_top marks must satisfy 1 <= lo < hi < depth");
  end

  logic [1:0] in_ctrl, in_skip, hd_ctrl, hd_skip;
  logic [19:0] head;
  logic [CW-1:0] level;
  logic fifo_full, fifo_empty;
  logic wr, del, pop, ins_ok;
  logic [9:0] skip_sym;

  rmf_cls u_cls_in
  (
    .word(in_data),
    .match_pattern(match_pattern),
    .is_ctrl(in_ctrl),
    .is_skip(in_skip)
  );

  rmf_cls u_cls_hd
  (
    .word(head),
    .match_pattern(match_pattern),
    .is_ctrl(hd_ctrl),
    .is_skip(hd_skip)
  );

  rmf_fifo #(
    .WIDTH(rmf_pkg::RMF_WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo
  (
    .core_clk(core_clk),
    .rst(rst),
    .wr_en(wr),
    .wr_data(in_data),
    .rd_en(pop),
    .rd_data(head),
    .level(level),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  assign skip_sym = match_pattern[9:0];

  // ****************************************
  // write side: cluster tracking and deletion
  // ****************************************
  rmf_pkg::rmf_clus_t wclus_q, wclus_d;
  logic [2:0] wskip_q, wskip_d, wdel_q, wdel_d;
  logic del_q, drop_q, drop_d;

  always_comb
  begin
    wclus_d = wclus_q;
    wskip_d = wskip_q;
    wdel_d = wdel_q;
    wr = 1'b0;
    del = 1'b0;
    if (in_valid)
    begin
      if (!sync_ok)
      begin
        wclus_d = rmf_pkg::rmf_outside;
        wr = 1'b1;
      end
      else if (!dw_mode)
      begin
        if (in_ctrl[0])
        begin
          wclus_d = rmf_pkg::rmf_inside;
          wskip_d = rmf_pkg::RMF_CNT_ZERO;
          wdel_d = rmf_pkg::RMF_CNT_ZERO;
          wr = 1'b1;
        end
        else if (in_skip[0] && wclus_q == rmf_pkg::rmf_inside)
        begin
          if (wskip_q != rmf_pkg::RMF_CNT_ZERO && wdel_q < rmf_pkg::RMF_SW_MAX_DEL && level >= CW'(HI_MARK))
          begin
            del = 1'b1;
            wdel_d = rmf_pkg::rmf_inc(wdel_q);
          end
          else
          begin
            wr = 1'b1;
            wskip_d = rmf_pkg::rmf_inc(wskip_q);
          end
        end
        else
        begin
          wclus_d = rmf_pkg::rmf_outside;
          wr = 1'b1;
        end
      end
      else
      begin
        if (in_skip == 2'h3 && wclus_q == rmf_pkg::rmf_inside && level >= CW'(HI_MARK))
          del = 1'b1;
        else
        begin
          wr = 1'b1;
          if (|in_ctrl)
            wclus_d = rmf_pkg::rmf_inside;
          else if (!(|in_skip))
            wclus_d = rmf_pkg::rmf_outside;
        end
      end
    end
    drop_d = wr && fifo_full;
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      wclus_q <= rmf_pkg::rmf_outside;
      wskip_q <= rmf_pkg::RMF_CNT_ZERO;
      wdel_q <= rmf_pkg::RMF_CNT_ZERO;
      del_q <= 1'b0;
      drop_q <= 1'b0;
    end
    else
    begin
      wclus_q <= wclus_d;
      wskip_q <= wskip_d;
      wdel_q <= wdel_d;
      del_q <= del;
      drop_q <= drop_d;
    end
  end

  // ****************************************
  // read side: insertion, filler and pop
  // ****************************************
  rmf_pkg::rmf_clus_t rclus_q, rclus_d;
  logic [2:0] rskip_q, rskip_d, rins_q, rins_d;
  logic lskip_q, lskip_d;
  logic ov_q, ov_d, fill_q, fill_d, ins_q;
  logic [19:0] od_q, od_d;
  logic [CW-1:0] lvl_q;

  always_comb
  begin
    rclus_d = rclus_q;
    rskip_d = rskip_q;
    rins_d = rins_q;
    lskip_d = lskip_q;
    ov_d = 1'b0;
    fill_d = 1'b0;
    od_d = od_q;
    pop = 1'b0;
    ins_ok = out_req && sync_ok && lskip_q && rclus_q == rmf_pkg::rmf_inside && level <= CW'(LO_MARK)
      && (dw_mode || (rins_q < rmf_pkg::RMF_SW_MAX_INS && rskip_q < rmf_pkg::RMF_SW_MAX_CLUS));
    if (out_req)
    begin
      ov_d = 1'b1;
      if (ins_ok)
      begin
        od_d = dw_mode ? {skip_sym, skip_sym} : {rmf_pkg::RMF_ZERO, skip_sym};
        rskip_d = rmf_pkg::rmf_inc(rskip_q);
        rins_d = rmf_pkg::rmf_inc(rins_q);
      end
      else if (fifo_empty)
      begin
        od_d = dw_mode ? {rmf_pkg::RMF_FILL, rmf_pkg::RMF_FILL} : {rmf_pkg::RMF_ZERO, rmf_pkg::RMF_FILL};
        fill_d = 1'b1;
        lskip_d = 1'b0;
      end
      else
      begin
        pop = 1'b1;
        od_d = head;
        if (!dw_mode)
        begin
          lskip_d = hd_skip[0] && rclus_q == rmf_pkg::rmf_inside;
          if (hd_ctrl[0])
          begin
            rclus_d = rmf_pkg::rmf_inside;
            rskip_d = rmf_pkg::RMF_CNT_ZERO;
            rins_d = rmf_pkg::RMF_CNT_ZERO;
          end
          else if (hd_skip[0] && rclus_q == rmf_pkg::rmf_inside)
            rskip_d = rmf_pkg::rmf_inc(rskip_q);
          else
            rclus_d = rmf_pkg::rmf_outside;
        end
        else
        begin
          lskip_d = hd_skip[1] && (rclus_q == rmf_pkg::rmf_inside || hd_ctrl[0]);
          if (|hd_ctrl)
            rclus_d = rmf_pkg::rmf_inside;
          else if (!(|hd_skip))
            rclus_d = rmf_pkg::rmf_outside;
        end
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      rclus_q <= rmf_pkg::rmf_outside;
      rskip_q <= rmf_pkg::RMF_CNT_ZERO;
      rins_q <= rmf_pkg::RMF_CNT_ZERO;
      lskip_q <= 1'b0;
      ov_q <= 1'b0;
      fill_q <= 1'b0;
      ins_q <= 1'b0;
      od_q <= '0;
      lvl_q <= '0;
    end
    else
    begin
      rclus_q <= rclus_d;
      rskip_q <= rskip_d;
      rins_q <= rins_d;
      lskip_q <= lskip_d;
      ov_q <= ov_d;
      fill_q <= fill_d;
      ins_q <= ins_ok;
      od_q <= od_d;
      lvl_q <= level;
    end
  end

  assign out_valid = ov_q;
  assign out_data = od_q;
  assign out_filler = fill_q;
  assign rm_del = del_q;
  assign rm_ins = ins_q;
  assign full_drop = drop_q;
  assign fifo_level = lvl_q;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  sequence s_empty_read;
    out_req && fifo_empty && !ins_ok;
  endsequence

  sequence s_filler_out;
    out_valid && out_filler && out_data[9:0] == rmf_pkg::RMF_FILL;
  endsequence

  chk_sync_gate: assert property (rm_del || rm_ins |-> $past(sync_ok))
    else $error("skip edit made while unaligned");
  chk_del_level: assert property (rm_del |-> $past(level) >= CW'(HI_MARK))
    else $error("deletion below high mark");
  chk_ins_level: assert property (rm_ins |-> $past(level) <= CW'(LO_MARK) && out_valid)
    else $error("insertion above low mark");
  chk_sw_ins_cap: assert property (rm_ins && !$past(dw_mode) |-> $past(rins_q) < 3'h4 && $past(rskip_q) < 3'h5)
    else $error("single width insertion over cluster limit");
  chk_sw_del_keep: assert property (rm_del && !$past(dw_mode) |-> $past(wskip_q) != 3'h0 && $past(wdel_q) < 3'h4)
    else $error("single width deletion left no skip or over four");
  chk_full_drop: assert property (in_valid && wr && fifo_full
    |=> full_drop && level == $past(level) - CW'($past(pop)))
    else $error("write at full not dropped");
  chk_empty_fill: assert property (s_empty_read |=> s_filler_out)
    else $error("no filler after fifo emptied");
  chk_dw_pair_ins: assert property (rm_ins && $past(dw_mode) |-> out_data == {skip_sym, skip_sym})
    else $error("double width insertion not a pair");
  chk_dw_pair_del: assert property (rm_del && $past(dw_mode) |-> $past(in_skip) == 2'h3)
    else $error("double width deletion not a whole pair");
  chk_dw_fill: assert property (s_empty_read and dw_mode |=> out_data == {rmf_pkg::RMF_FILL, rmf_pkg::RMF_FILL})
    else $error("double width filler not a pair");

endmodule

// File: bench/rmf_far.sv
// far side model: aligned symbol source and downstream slot reader
// assumes its tasks are called at a falling clock edge
`timescale 1ns/1ps
module rmf_far
(
  input wire logic core_clk,
  output logic in_valid,
  output logic [19:0] in_data,
  output logic out_req,
  input wire logic out_valid,
  input wire logic [19:0] out_data,
  input wire logic out_filler,
  input wire logic rm_ins,
  input wire logic rm_del,
  input wire logic full_drop
);
  logic [19:0] tx_q[$];
  logic [21:0] rx_q[$];
  int del_cnt = 0;
  int drop_cnt = 0;
  int bad_cnt = 0;

  initial
  begin
    in_valid = 1'b0;
    in_data = 20'h00000;
    out_req = 1'b0;
  end

  // count single cycle pulses
  always @(negedge core_clk)
  begin
    if (rm_del === 1'b1)
      del_cnt++;
    if (full_drop === 1'b1)
      drop_cnt++;
  end

  // a used lane of a coded symbol holds four to six ones
  function automatic logic lane_ok(input logic [9:0] s);
    lane_ok = $countones(s) >= 4 && $countones(s) <= 6;
  endfunction

  task automatic send_all();
    logic [19:0] w;
    w = 20'h00000;
    while (tx_q.size() > 0)
    begin
      w = tx_q.pop_front();
      if (!lane_ok(w[9:0]) || (w[19:10] != 10'h000 && !lane_ok(w[19:10])))
        bad_cnt++;
      in_valid = 1'b1;
      in_data = w;
      @(posedge core_clk);
      @(negedge core_clk);
    end
    in_valid = 1'b0;
    in_data = ~w;
    @(negedge core_clk);
  endtask

  // one slot per cycle, answer one cycle later
  task automatic pull(input int n);
    out_req = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      @(negedge core_clk);
      if (out_valid !== 1'b1)
        bad_cnt++;
      rx_q.push_back({out_filler, rm_ins, out_data});
      if (i == n - 1)
        out_req = 1'b0;
    end
    @(negedge core_clk);
  endtask
endmodule

// File: bench/tb_rmf_top.sv
// rate match fifo bench: deletion, insertion, full and empty cases
// assumes the far side model drives the stream ports
`timescale 1ns/1ps
module tb_rmf_top;
  localparam logic [9:0] CTA = 10'h17C;
  localparam logic [9:0] SKA = 10'h0F4;
  localparam logic [9:0] CTB = 10'h283;
  localparam logic [9:0] SKB = 10'h30B;
  localparam logic [9:0] DTA = 10'h15A;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic sync_ok = 1'b0;
  logic dw_mode = 1'b0;
  logic [19:0] match_pattern = 20'h00000;
  logic in_valid, out_req, out_valid, out_filler, rm_del, rm_ins, full_drop;
  logic [19:0] in_data, out_data;
  logic [4:0] fifo_level;
  int errors = 0;
  int checks_done = 0;

  rmf_top i_dut (.core_clk(core_clk), .rst(rst), .sync_ok(sync_ok), .dw_mode(dw_mode),
    .match_pattern(match_pattern), .in_valid(in_valid), .in_data(in_data), .out_req(out_req),
    .out_valid(out_valid), .out_data(out_data), .out_filler(out_filler), .rm_del(rm_del),
    .rm_ins(rm_ins), .full_drop(full_drop), .fifo_level(fifo_level));
  rmf_far i_far (.core_clk(core_clk), .in_valid(in_valid), .in_data(in_data), .out_req(out_req),
    .out_valid(out_valid), .out_data(out_data), .out_filler(out_filler), .rm_ins(rm_ins),
    .rm_del(rm_del), .full_drop(full_drop));

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  // ****************************************
  // helpers
  // ****************************************
  task automatic check(input logic [21:0] got, input logic [21:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // coded data word: five ones per used lane, never a pattern
  function automatic logic [19:0] dat(input int i, input logic dw);
    logic [4:0] v;
    v = 5'(i);
    dat = {dw ? {~v, v} : 10'h000, v, ~v};
  endfunction

  task automatic nxt(input logic [21:0] exp);
    check(i_far.rx_q.pop_front(), exp);
  endtask

  task automatic do_reset(input logic dw, input logic [19:0] pat, input logic sy);
    rst = 1'b1;
    dw_mode = dw;
    match_pattern = pat;
    sync_ok = sy;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
  endtask

  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_full(input logic dw);
    int d0;
    do_reset(dw, {CTA, SKA}, 1'b1);
    d0 = i_far.drop_cnt;
    for (int i = 0; i < 17; i++)
      i_far.tx_q.push_back(dat(i, dw));
    i_far.send_all();
    check(22'(i_far.drop_cnt - d0), 22'h000001);
    check(22'(fifo_level), 22'h000010);
    i_far.pull(17);
    for (int i = 0; i < 16; i++)
      nxt({2'h0, dat(i, dw)});
    nxt({2'h2, dw ? {rmf_pkg::RMF_FILL, rmf_pkg::RMF_FILL} : {rmf_pkg::RMF_ZERO, rmf_pkg::RMF_FILL}});
  endtask

  task automatic t_del_sw(input logic sy);
    int d0;
    int kept;
    kept = sy ? 2 : 3;
    do_reset(1'b0, {CTA, SKA}, sy);
    d0 = i_far.del_cnt;
    for (int i = 0; i < 12; i++)
      i_far.tx_q.push_back(dat(i, 1'b0));
    i_far.tx_q.push_back({10'h000, CTA});
    for (int i = 0; i < (sy ? 6 : 3); i++)
      i_far.tx_q.push_back({10'h000, SKA});
    i_far.send_all();
    check(22'(i_far.del_cnt - d0), sy ? 22'h000004 : 22'h000000);
    sync_ok = 1'b0;
    i_far.pull(13 + kept);
    for (int i = 0; i < 12; i++)
      nxt({2'h0, dat(i, 1'b0)});
    nxt({12'h000, CTA});
    for (int i = 0; i < kept; i++)
      nxt({12'h000, SKA});
  endtask

  task automatic t_del_dw();
    int d0;
    logic [19:0] kw[3];
    kw = '{{SKA, CTA}, {DTA, SKA}, {CTA, DTA}};
    do_reset(1'b1, {CTA, SKA}, 1'b1);
    d0 = i_far.del_cnt;
    for (int i = 0; i < 12; i++)
      i_far.tx_q.push_back(dat(i, 1'b1));
    for (int i = 0; i < 3; i++)
      i_far.tx_q.push_back(kw[i]);
    i_far.tx_q.push_back({SKA, SKA});
    i_far.tx_q.push_back({SKA, SKA});
    i_far.send_all();
    check(22'(i_far.del_cnt - d0), 22'h000002);
    sync_ok = 1'b0;
    i_far.pull(15);
    for (int i = 0; i < 12; i++)
      nxt({2'h0, dat(i, 1'b1)});
    for (int i = 0; i < 3; i++)
      nxt({2'h0, kw[i]});
  endtask

  task automatic t_ins(input logic dw);
    logic [19:0] sk;
    sk = dw ? {SKB, SKB} : {10'h000, SKB};
    do_reset(dw, {CTB, SKB}, 1'b1);
    if (dw)
      i_far.tx_q.push_back({SKB, CTB});
    else
    begin
      i_far.tx_q.push_back({10'h000, CTB});
      i_far.tx_q.push_back(sk);
    end
    i_far.tx_q.push_back(dat(5, dw));
    i_far.send_all();
    i_far.pull(dw ? 3 : 6);
    if (dw)
      nxt({2'h0, SKB, CTB});
    else
    begin
      nxt({12'h000, CTB});
      nxt({2'h0, sk});
    end
    for (int i = 0; i < (dw ? 2 : 4); i++)
      nxt({2'h1, sk});
    sync_ok = ~dw;
    i_far.pull(2);
    nxt({2'h0, dat(5, dw)});
    nxt({2'h2, dw ? {rmf_pkg::RMF_FILL, rmf_pkg::RMF_FILL} : {rmf_pkg::RMF_ZERO, rmf_pkg::RMF_FILL}});
  endtask

  initial
  begin
    @(negedge core_clk);
    t_full(1'b0);
    t_full(1'b1);
    t_del_sw(1'b1);
    t_del_sw(1'b0);
    t_del_dw();
    t_ins(1'b0);
    t_ins(1'b1);
    check(22'(i_far.bad_cnt), 22'h000000);
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors++;
    complete_run();
  end
endmodule
